// file: verilog/vad_decode.sv
// virtual address segment decode, translation buffer and byte lane placement
//
// Contract
// RQ1: translation buffer holds exactly 32 entries
// RQ2: 32-bit mode masks upper half on reads
// RQ3: byte, halfword, word and doubleword sizes
// RQ4: endian select bit; only little-endian accepted
// RQ5: lowest address byte sits in bits 7:0
// RQ6: multi-byte operand addressed by its lowest byte
// RQ7: 32-bit mode sign-extends bit 31 upward
// RQ8: mapped accesses use translation buffer physical address
// RQ9: direct segments bypass buffer by bit changes
// RQ10: decode per width and privilege mode
// RQ11: kernel 32-bit direct segments clear top bits
// RQ12: kernel 32-bit low and top segments mapped
`timescale 1ns/1ps
module vad_decode
	import vad_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	// access request from the address calculation stage
	input wire logic req_valid_i,
	input wire logic [63:0] req_vaddr_i,
	input wire logic req_wide_i,
	input wire vad_priv_t req_priv_i,
	input wire vad_size_t req_size_i,
	input wire logic [63:0] req_wdata_i,
	input wire logic endian_select_bit_i,
	// translation buffer write port
	input wire logic tlb_we_i,
	input wire logic [VAD_IDX_W-1:0] tlb_idx_i,
	input wire logic [VAD_VPN_W-1:0] tlb_vpn_i,
	input wire logic [VAD_PFN_W-1:0] tlb_pfn_i,
	input wire logic tlb_valid_i,
	// coprocessor register read path
	input wire logic cop_rd_i,
	input wire logic [63:0] cop_rdata_i,
	input wire logic cop_wide_i,
	// registered answer, one cycle after the request
	output logic rsp_valid_o,
	output logic [63:0] rsp_vaddr_o,
	output logic [VAD_PA_W-1:0] rsp_paddr_o,
	output logic rsp_mapped_o,
	output logic rsp_uncached_o,
	output logic rsp_miss_o,
	output logic rsp_addr_err_o,
	output logic rsp_align_err_o,
	output logic rsp_endian_err_o,
	output logic [7:0] rsp_lanes_o,
	output logic [63:0] rsp_wdata_o,
	output logic cop_valid_o,
	output logic [63:0] cop_rdata_o
);
	// translation buffer storage, one slot per index
	logic [VAD_VPN_W-1:0] vpn_reg [VAD_TLB_ENTRIES];
	logic [VAD_PFN_W-1:0] pfn_reg [VAD_TLB_ENTRIES];
	logic [VAD_TLB_ENTRIES-1:0] tv_reg;
	logic [VAD_VPN_W-1:0] vpn_next [VAD_TLB_ENTRIES];
	logic [VAD_PFN_W-1:0] pfn_next [VAD_TLB_ENTRIES];
	logic [VAD_TLB_ENTRIES-1:0] tv_next;

	// answer registers
	logic rsp_valid_reg, rsp_valid_next;
	logic [63:0] rsp_vaddr_reg, rsp_vaddr_next;
	logic [VAD_PA_W-1:0] rsp_paddr_reg, rsp_paddr_next;
	logic rsp_mapped_reg, rsp_mapped_next;
	logic rsp_uncached_reg, rsp_uncached_next;
	logic rsp_miss_reg, rsp_miss_next;
	logic rsp_addr_err_reg, rsp_addr_err_next;
	logic rsp_align_err_reg, rsp_align_err_next;
	logic rsp_endian_err_reg, rsp_endian_err_next;
	logic [7:0] rsp_lanes_reg, rsp_lanes_next;
	logic [63:0] rsp_wdata_reg, rsp_wdata_next;
	logic cop_valid_reg, cop_valid_next;
	logic [63:0] cop_rdata_reg, cop_rdata_next;

	// decode intermediates
	logic [63:0] va;            // effective 64-bit virtual address
	logic [2:0] seg;            // top three bits of the low word
	logic sext_ok;              // bits 63:32 are a copy of bit 31
	logic hit;                  // some valid entry matches
	logic [VAD_PFN_W-1:0] hit_pfn;
	logic [VAD_VPN_W-1:0] look_vpn;

	// translation buffer update: one entry written per cycle
	always_comb begin
		for (int i = 0; i < VAD_TLB_ENTRIES; i++) begin
			vpn_next[i] = vpn_reg[i];
			pfn_next[i] = pfn_reg[i];
		end
		tv_next = tv_reg;
		if (tlb_we_i) begin
			// the index picks exactly one of the 32 slots [RQ1]
			vpn_next[tlb_idx_i] = tlb_vpn_i;
			pfn_next[tlb_idx_i] = tlb_pfn_i;
			tv_next[tlb_idx_i] = tlb_valid_i;
		end
	end

	// fully associative lookup; the lowest matching index wins so that
	// duplicate entries written by software still give one answer
	always_comb begin
		look_vpn = va[VAD_PAGE_SHIFT+VAD_VPN_W-1:VAD_PAGE_SHIFT];
		hit = 1'b0;
		hit_pfn = '0;
		for (int i = VAD_TLB_ENTRIES - 1; i >= 0; i--) begin
			if (tv_reg[i] && vpn_reg[i] == look_vpn) begin
				hit = 1'b1;
				hit_pfn = pfn_reg[i];
			end
		end
	end

	// segment classification, translation and lane placement
	always_comb begin
		logic mapped, uncached, aerr, lerr;
		logic [VAD_PA_W-1:0] pa;
		logic [7:0] base;
		logic [5:0] shamt;
		mapped = 1'b0;
		uncached = 1'b0;
		aerr = 1'b0;
		lerr = 1'b0;
		pa = '0;
		base = 8'h00;
		shamt = 6'h00;
		// 32-bit mode copies bit 31 into the upper half [RQ7]
		if (req_wide_i) begin
			va = req_vaddr_i;
		end else begin
			va = {{32{req_vaddr_i[31]}}, req_vaddr_i[31:0]};
		end
		seg = va[31:29];
		sext_ok = (va[63:32] == {32{va[31]}});

		// layout differs per width and privilege [RQ10]
		if (!req_wide_i) begin
			unique case (req_priv_i)
				VAD_USER: begin
					// only the low 2 GiB is reachable
					mapped = !va[31];
					aerr = va[31];
				end
				VAD_SUPER: begin
					// low 2 GiB plus the 0xC000_0000 half-gigabyte
					mapped = !va[31] || seg == VAD_SEG_SUPER;
					aerr = !mapped;
				end
				VAD_KERNEL: begin
					if (seg == VAD_SEG_CACHED) begin
						// direct cached segment [RQ11]
						pa = {3'h0, va[28:0]};
					end else if (seg == VAD_SEG_UNCACHED) begin
						// direct uncached segment [RQ11]
						pa = {3'h0, va[28:0]};
						uncached = 1'b1;
					end else begin
						// low half and top segments go through the buffer [RQ12]
						mapped = 1'b1;
					end
				end
				default: begin
					// undefined privilege code is refused
					aerr = 1'b1;
				end
			endcase
		end else begin
			unique case (req_priv_i)
				VAD_USER: begin
					// 1 TiB user region from address zero
					mapped = (va[63:40] == 24'h000000);
					aerr = !mapped;
				end
				VAD_SUPER: begin
					mapped = (va[63:40] == 24'h000000) ||
						(va[63:62] == VAD_XR_SUPER && va[61:40] == 22'h0) ||
						(sext_ok && va[31] && seg == VAD_SEG_SUPER);
					aerr = !mapped;
				end
				VAD_KERNEL: begin
					if (sext_ok && va[31]) begin
						// compatibility window at the very top
						if (seg == VAD_SEG_CACHED || seg == VAD_SEG_UNCACHED) begin
							pa = {3'h0, va[28:0]};  // [RQ9]
							uncached = (seg == VAD_SEG_UNCACHED);
						end else begin
							mapped = 1'b1;
						end
					end else if (va[63:62] == VAD_XR_PHYS) begin
						// direct region: bits 61:59 carry the cache attribute
						aerr = (va[58:32] != 27'h0);
						pa = va[31:0];  // [RQ9]
						uncached = (va[61:59] == VAD_XPHYS_UNCACHED);
					end else if (va[63:62] == VAD_XR_KERN) begin
						mapped = (va[61:40] == 22'h0);
						aerr = !mapped;
					end else begin
						// user or supervisor region seen from kernel
						mapped = (va[61:40] == 22'h0);
						aerr = !mapped;
					end
				end
				default: begin
					aerr = 1'b1;
				end
			endcase
		end

		// mapped accesses take the frame from the buffer [RQ8]
		if (mapped) begin
			pa = {hit_pfn, va[VAD_PAGE_SHIFT-1:0]};
		end

		// lanes by size; the operand starts at its lowest byte [RQ3] [RQ6]
		unique case (req_size_i)
			VAD_BYTE: base = 8'h01;
			VAD_HALF: begin
				base = 8'h03;
				lerr = va[0];
			end
			VAD_WORD: begin
				base = 8'h0F;
				lerr = (va[1:0] != 2'h0);
			end
			VAD_DWORD: begin
				base = 8'hFF;
				lerr = (va[2:0] != 3'h0);
			end
		endcase
		// lowest address lands in bits 7:0, later bytes move up [RQ5]
		shamt = {va[2:0], 3'h0};
		rsp_lanes_next = lerr ? 8'h00 : 8'((base << va[2:0]));
		rsp_wdata_next = req_wdata_i << shamt;

		// answer stands only for the request of the previous cycle
		rsp_valid_next = req_valid_i;
		rsp_vaddr_next = va;
		rsp_paddr_next = aerr ? '0 : pa;
		rsp_mapped_next = mapped && !aerr;
		rsp_uncached_next = uncached && !aerr && !mapped;
		rsp_miss_next = req_valid_i && mapped && !aerr && !hit;
		rsp_addr_err_next = req_valid_i && aerr;
		rsp_align_err_next = req_valid_i && lerr;
		// big-endian placement is not offered on this device [RQ4]
		rsp_endian_err_next = req_valid_i &&
			(endian_select_bit_i != VAD_LITTLE);

		// narrow mode hides the upper half of a register read [RQ2]
		cop_valid_next = cop_rd_i;
		cop_rdata_next = cop_wide_i ? cop_rdata_i :
			{32'h00000000, cop_rdata_i[31:0]};
	end

	// register stage; entries clear their valid bits on reset only,
	// the tag and frame contents need no reset value
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < VAD_TLB_ENTRIES; i++) begin
			vpn_reg[i] <= vpn_next[i];
			pfn_reg[i] <= pfn_next[i];
		end
		if (!rst_n_i) begin
			tv_reg <= '0;
			rsp_valid_reg <= 1'b0;
			rsp_vaddr_reg <= '0;
			rsp_paddr_reg <= '0;
			rsp_mapped_reg <= 1'b0;
			rsp_uncached_reg <= 1'b0;
			rsp_miss_reg <= 1'b0;
			rsp_addr_err_reg <= 1'b0;
			rsp_align_err_reg <= 1'b0;
			rsp_endian_err_reg <= 1'b0;
			rsp_lanes_reg <= 8'h00;
			rsp_wdata_reg <= '0;
			cop_valid_reg <= 1'b0;
			cop_rdata_reg <= '0;
		end else begin
			tv_reg <= tv_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_vaddr_reg <= rsp_vaddr_next;
			rsp_paddr_reg <= rsp_paddr_next;
			rsp_mapped_reg <= rsp_mapped_next;
			rsp_uncached_reg <= rsp_uncached_next;
			rsp_miss_reg <= rsp_miss_next;
			rsp_addr_err_reg <= rsp_addr_err_next;
			rsp_align_err_reg <= rsp_align_err_next;
			rsp_endian_err_reg <= rsp_endian_err_next;
			rsp_lanes_reg <= rsp_lanes_next;
			rsp_wdata_reg <= rsp_wdata_next;
			cop_valid_reg <= cop_valid_next;
			cop_rdata_reg <= cop_rdata_next;
		end
	end

	// every output comes straight from a flip-flop
	assign rsp_valid_o = rsp_valid_reg;
	assign rsp_vaddr_o = rsp_vaddr_reg;
	assign rsp_paddr_o = rsp_paddr_reg;
	assign rsp_mapped_o = rsp_mapped_reg;
	assign rsp_uncached_o = rsp_uncached_reg;
	assign rsp_miss_o = rsp_miss_reg;
	assign rsp_addr_err_o = rsp_addr_err_reg;
	assign rsp_align_err_o = rsp_align_err_reg;
	assign rsp_endian_err_o = rsp_endian_err_reg;
	assign rsp_lanes_o = rsp_lanes_reg;
	assign rsp_wdata_o = rsp_wdata_reg;
	assign cop_valid_o = cop_valid_reg;
	assign cop_rdata_o = cop_rdata_reg;
endmodule

// file: verilog/vad_pkg.sv
// shared constants and types for the virtual address segment decoder
package vad_pkg;
	// privilege modes presented by the pipeline
	typedef enum logic [1:0] {VAD_USER, VAD_SUPER, VAD_KERNEL} vad_priv_t;
	// operand sizes of a load or store
	typedef enum logic [1:0] {VAD_BYTE, VAD_HALF, VAD_WORD, VAD_DWORD}
		vad_size_t;

	localparam int VAD_TLB_ENTRIES = 32;    // translation buffer depth
	localparam int VAD_IDX_W = 5;           // entry index width
	localparam int VAD_PAGE_SHIFT = 12;     // fixed 4 KiB page
	localparam int VAD_VPN_W = 28;          // covers a 1 TiB mapped region
	localparam int VAD_PFN_W = 20;          // 32-bit physical space
	localparam int VAD_PA_W = 32;           // physical address width

	// 32-bit view segment boundaries (top three bits of the low word)
	localparam logic [2:0] VAD_SEG_CACHED = 3'h4;   // 0x8000_0000
	localparam logic [2:0] VAD_SEG_UNCACHED = 3'h5; // 0xA000_0000
	localparam logic [2:0] VAD_SEG_SUPER = 3'h6;    // 0xC000_0000
	// 64-bit region selectors held in bits 63:62
	localparam logic [1:0] VAD_XR_USER = 2'h0;
	localparam logic [1:0] VAD_XR_SUPER = 2'h1;
	localparam logic [1:0] VAD_XR_PHYS = 2'h2;
	localparam logic [1:0] VAD_XR_KERN = 2'h3;
	// cache attribute of the direct 64-bit region that means uncached
	localparam logic [2:0] VAD_XPHYS_UNCACHED = 3'h2;
	// endian select value for little-endian placement
	localparam logic VAD_LITTLE = 1'b0;
endpackage

// file: verification/vad_pipe_model.sv
// pipeline address stage model issuing single requests
`timescale 1ns/1ps
module vad_pipe_model
	import vad_pkg::*;
(
	input wire logic clk_i,
	output logic req_valid_o,
	output logic [63:0] req_vaddr_o,
	output logic req_wide_o,
	output vad_priv_t req_priv_o,
	output vad_size_t req_size_o,
	output logic [63:0] req_wdata_o
);
	// idle values from time zero
	initial begin
		req_valid_o = 1'b0;
		req_vaddr_o = 64'h0;
		req_wide_o = 1'b0;
		req_priv_o = VAD_KERNEL;
		req_size_o = VAD_BYTE;
		req_wdata_o = 64'h0;
	end
	// hold one edge, then drop strobe; address inverts so stale
	// values can never be mistaken for a live request
	task automatic issue(input logic [63:0] va, input logic w,
		input vad_priv_t p, input vad_size_t s, input logic [63:0] d);
		@(posedge clk_i);
		req_valid_o <= 1'b1;
		req_vaddr_o <= va;
		req_wide_o <= w;
		req_priv_o <= p;
		req_size_o <= s;
		req_wdata_o <= d;
		@(posedge clk_i);
		req_valid_o <= 1'b0;
		req_vaddr_o <= ~va;
		#1;
	endtask
endmodule

// file: verification/vad_decode_chk.sv
// timing and value checker for the segment decoder
`timescale 1ns/1ps
module vad_decode_chk
	import vad_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire logic [63:0] req_vaddr_i,
	input wire logic req_wide_i,
	input wire vad_priv_t req_priv_i,
	input wire vad_size_t req_size_i,
	input wire logic endian_select_bit_i,
	input wire logic cop_rd_i,
	input wire logic [63:0] cop_rdata_i,
	input wire logic cop_wide_i,
	input wire logic rsp_valid_o,
	input wire logic [63:0] rsp_vaddr_o,
	input wire logic [VAD_PA_W-1:0] rsp_paddr_o,
	input wire logic rsp_mapped_o,
	input wire logic rsp_uncached_o,
	input wire logic rsp_align_err_o,
	input wire logic rsp_endian_err_o,
	input wire logic [7:0] rsp_lanes_o,
	input wire logic cop_valid_o,
	input wire logic [63:0] cop_rdata_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [31:0] va_reg; // low word of the address input one cycle ago
	logic kn; // kernel narrow request
	assign kn = req_valid_i && !req_wide_i && req_priv_i == VAD_KERNEL;
	// keep the low word so sliced checks need no $past slice
	always_ff @(posedge clk_i) begin
		va_reg <= req_vaddr_i[31:0];
	end
	a_rsp_follows: assert property (req_valid_i |=> rsp_valid_o)
		else $error("answer missing");
	a_rsp_quiet: assert property (!req_valid_i |=> !rsp_valid_o)
		else $error("answer without request");
	a_narrow_sext: assert property (req_valid_i && !req_wide_i |=>
		rsp_vaddr_o == {{32{va_reg[31]}}, va_reg}) else $error("sext");
	a_direct_bypass: assert property (kn && req_vaddr_i[31:30] == 2'h2
		|=> !rsp_mapped_o && rsp_paddr_o == {3'h0, va_reg[28:0]}
		&& rsp_uncached_o == va_reg[29]) else $error("direct segment");
	a_kernel_mapped: assert property (kn && req_vaddr_i[31:30] != 2'h2
		|=> rsp_mapped_o && !rsp_uncached_o) else $error("mapped segment");
	a_byte_lane: assert property (req_valid_i && req_size_i == VAD_BYTE
		|=> rsp_lanes_o == 8'h01 << va_reg[2:0]) else $error("byte lane");
	a_dword_lane: assert property (req_valid_i && req_size_i == VAD_DWORD
		&& req_vaddr_i[2:0] == 3'h0 |=> rsp_lanes_o == 8'hFF
		&& !rsp_align_err_o) else $error("dword lanes");
	a_endian_flag: assert property (req_valid_i && endian_select_bit_i
		|=> rsp_endian_err_o) else $error("endian flag");
	a_cop_mask: assert property (cop_rd_i && !cop_wide_i |=> cop_valid_o
		&& cop_rdata_o[63:32] == 32'h0) else $error("narrow read");
	a_cop_wide: assert property (cop_rd_i && cop_wide_i |=>
		cop_rdata_o == $past(cop_rdata_i)) else $error("wide read");
	c_uncached: cover property (kn && req_vaddr_i[31:29] == 3'h5);
	c_misaligned: cover property (rsp_valid_o && rsp_align_err_o);
	c_narrow_read: cover property (cop_rd_i && !cop_wide_i);
endmodule
bind vad_decode vad_decode_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.req_valid_i(req_valid_i), .req_vaddr_i(req_vaddr_i),
	.req_wide_i(req_wide_i), .req_priv_i(req_priv_i),
	.req_size_i(req_size_i), .endian_select_bit_i(endian_select_bit_i),
	.cop_rd_i(cop_rd_i), .cop_rdata_i(cop_rdata_i), .cop_wide_i(cop_wide_i),
	.rsp_valid_o(rsp_valid_o), .rsp_vaddr_o(rsp_vaddr_o),
	.rsp_paddr_o(rsp_paddr_o), .rsp_mapped_o(rsp_mapped_o),
	.rsp_uncached_o(rsp_uncached_o), .rsp_align_err_o(rsp_align_err_o),
	.rsp_endian_err_o(rsp_endian_err_o), .rsp_lanes_o(rsp_lanes_o),
	.cop_valid_o(cop_valid_o), .cop_rdata_o(cop_rdata_o));

// file: verification/vad_decode_bench.sv
// self-checking bench for the segment decoder
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module vad_decode_bench import vad_pkg::*;;
	logic clk_i = 0, rst_n_i = 0, endian = 0, we = 0, tv = 0;
	logic crd = 0, cw = 0; // coprocessor read strobe and width
	logic [VAD_IDX_W-1:0] idx = 0;
	logic [VAD_VPN_W-1:0] vpn = 0;
	logic [VAD_PFN_W-1:0] pfn = 0;
	logic [63:0] cd = 64'h0, va, wd, o_va, o_wd, c_d;
	logic rv, rw, o_v, o_m, o_u, o_mi, o_ae, o_al, o_ee, c_v;
	vad_priv_t pr;
	vad_size_t sz;
	logic [VAD_PA_W-1:0] o_pa;
	logic [7:0] o_ln;
	int mismatches = 0, n_tests = 0;
	vad_pipe_model pipe (.clk_i(clk_i), .req_valid_o(rv), .req_vaddr_o(va),
		.req_wide_o(rw), .req_priv_o(pr), .req_size_o(sz), .req_wdata_o(wd));
	vad_decode uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(rv),
		.req_vaddr_i(va), .req_wide_i(rw), .req_priv_i(pr), .req_size_i(sz),
		.req_wdata_i(wd), .endian_select_bit_i(endian), .tlb_we_i(we),
		.tlb_idx_i(idx), .tlb_vpn_i(vpn), .tlb_pfn_i(pfn), .tlb_valid_i(tv),
		.cop_rd_i(crd), .cop_rdata_i(cd), .cop_wide_i(cw), .rsp_valid_o(o_v),
		.rsp_vaddr_o(o_va), .rsp_paddr_o(o_pa), .rsp_mapped_o(o_m),
		.rsp_uncached_o(o_u), .rsp_miss_o(o_mi), .rsp_addr_err_o(o_ae),
		.rsp_align_err_o(o_al), .rsp_endian_err_o(o_ee), .rsp_lanes_o(o_ln),
		.rsp_wdata_o(o_wd), .cop_valid_o(c_v), .cop_rdata_o(c_d));
	// 200 MHz clock
	initial forever #2.5 clk_i = ~clk_i;
	// verdict and end of run
	task automatic results;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// kernel narrow segments; junk upper half must be replaced
	task automatic t_segments;
		logic [31:0] a[4] = '{32'h2000, 32'h8000_1234, 32'hA000_1238,
			32'hE000_0010};
		for (int i = 0; i < 4; i++) begin
			pipe.issue({32'h5A5A_0F0F, a[i]}, 1'b0, VAD_KERNEL, VAD_BYTE, 64'h0);
			`CHK(o_va, {{32{a[i][31]}}, a[i]})
			`CHK(o_m, a[i][31:30] != 2'h2)
			`CHK(o_u, a[i][31:29] == 3'h5)
			if (!o_m) `CHK(o_pa, {3'h0, a[i][28:0]})
		end
	endtask
	// miss after reset, write the last entry, then hit and miss
	task automatic t_tlb;
		pipe.issue(64'h5ABC, 1'b0, VAD_KERNEL, VAD_WORD, 64'h0);
		`CHK(o_mi, 1'b1)
		@(posedge clk_i);
		we <= 1'b1;
		idx <= 5'h1F;
		vpn <= 28'h5;
		pfn <= 20'hABCDE;
		tv <= 1'b1;
		@(posedge clk_i);
		we <= 1'b0;
		pipe.issue(64'h5ABC, 1'b0, VAD_KERNEL, VAD_WORD, 64'h0);
		`CHK({o_mi, o_pa}, {1'b0, 32'hABCD_EABC})
		pipe.issue(64'h6ABC, 1'b0, VAD_KERNEL, VAD_WORD, 64'h0);
		`CHK(o_mi, 1'b1)
	endtask
	// every size at an offset, plus one misaligned word
	task automatic t_lanes;
		logic [63:0] d[5] = '{64'h5A, 64'h1234, 64'hCAFE_F00D,
			64'h0123_4567_89AB_CDEF, 64'h77};
		logic [2:0] off[5] = '{3'h3, 3'h6, 3'h4, 3'h0, 3'h2};
		logic [7:0] ln[5] = '{8'h08, 8'hC0, 8'hF0, 8'hFF, 8'h00};
		for (int i = 0; i < 5; i++) begin
			pipe.issue({61'h1000_0000, off[i]}, 1'b0, VAD_KERNEL,
				vad_size_t'(i == 4 ? 2 : i), d[i]);
			`CHK(o_ln, ln[i])
			`CHK(o_wd, d[i] << (8 * off[i]))
			`CHK(o_al, i == 4)
		end
	endtask
	// mid-run reset must drop the entry written earlier, so a miss follows
	task automatic t_reset;
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
		`CHK({o_v, o_mi, o_m}, 3'b000)
		pipe.issue(64'h5ABC, 1'b0, VAD_KERNEL, VAD_WORD, 64'h0);
		`CHK({o_v, o_mi}, 2'b11)
	endtask
	// space limits per width and privilege, undefined privilege refused
	task automatic t_modes;
		logic [63:0] a[9] = '{64'h8000_0000, 64'h7FFF_FFF0,
			64'hFF_FFFF_F000, 64'h100_0000_0000, 64'hC000_0000,
			64'hA000_0000, 64'h4000_0000_0000_1000,
			64'h8000_0001_0000_0000, 64'h1000};
		logic w[9] = '{0, 0, 1, 1, 0, 0, 1, 1, 0};
		vad_priv_t p[9] = '{VAD_USER, VAD_USER, VAD_USER, VAD_USER,
			VAD_SUPER, VAD_SUPER, VAD_SUPER, VAD_KERNEL, vad_priv_t'(2'h3)};
		logic e[9] = '{1, 0, 0, 1, 0, 1, 0, 1, 1};
		for (int i = 0; i < 9; i++) begin
			pipe.issue(a[i], w[i], p[i], VAD_WORD, 64'h0);
			`CHK(o_ae, e[i])
		end
		// 64-bit direct region with the uncached attribute
		pipe.issue(64'h9000_0000_0000_1000, 1'b1, VAD_KERNEL, VAD_WORD,
			64'h0);
		`CHK({o_ae, o_m, o_u, o_pa}, {3'b001, 32'h0000_1000})
		// sign-extended top window still bypasses the buffer
		pipe.issue(64'hFFFF_FFFF_A000_0040, 1'b1, VAD_KERNEL, VAD_WORD,
			64'h0);
		`CHK({o_ae, o_m, o_u, o_pa}, {3'b001, 32'h0000_0040})
	endtask
	// back-to-back narrow then wide coprocessor read
	task automatic t_cop;
		@(posedge clk_i);
		crd <= 1'b1;
		cd <= 64'hDEAD_BEEF_1234_5678;
		@(posedge clk_i);
		cw <= 1'b1;
		#1;
		`CHK({c_v, c_d}, {1'b1, 64'h1234_5678})
		@(posedge clk_i);
		crd <= 1'b0;
		#1;
		`CHK(c_d, 64'hDEAD_BEEF_1234_5678)
	endtask
	// big-endian request is flagged
	task automatic t_endian;
		@(posedge clk_i);
		endian <= 1'b1;
		pipe.issue(64'h8000_0000, 1'b0, VAD_KERNEL, VAD_BYTE, 64'h0);
		`CHK(o_ee, 1'b1)
		@(posedge clk_i);
		endian <= 1'b0;
	endtask
	// main sequence after six reset cycles
	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_segments();
		t_tlb();
		t_reset();
		t_lanes();
		t_modes();
		t_cop();
		t_endian();
		results();
	end
	// the tests need under 200 cycles; hang guard
	initial begin
		repeat (2000) @(posedge clk_i);
		mismatches++;
		results();
	end
endmodule
